// >>> src/eqsl_top.v
`timescale 1ns/100ps
`include "eqsl_consts.vh"
module eqsl_top (
  sys_clk,
  sys_rst,
  shift_clock,
  serial_in,
  load_latch_strobe,
  readback_strobe,
  clock_rate_select,
  power_down_pin,
  serial_out,
  slope_code,
  height_code,
  bandwidth_code,
  slope_droop_select,
  filter_bypass_n,
  filter_path_en,
  filter_clk_en,
  analog_power_en,
  analog_output_oe
);
  input wire sys_clk;
  input wire sys_rst;
  input wire shift_clock;
  input wire serial_in;
  input wire load_latch_strobe;
  input wire readback_strobe;
  input wire clock_rate_select;
  input wire power_down_pin;
  output reg serial_out;
  output reg [`EQSL_CODE_W-1:0] slope_code;
  output reg [`EQSL_CODE_W-1:0] height_code;
  output reg [`EQSL_CODE_W-1:0] bandwidth_code;
  output reg slope_droop_select;
  output reg filter_bypass_n;
  output reg filter_path_en;
  output reg filter_clk_en;
  output reg analog_power_en;
  output reg analog_output_oe;

  // ==========================================================
  // Input conditioning
  // ==========================================================
  // The serial pins have no tie to sys_clk, so each is filtered before use.
  wire sck_s;
  wire sid_s;
  wire load_latch_strobe_s;
  wire readback_strobe_s;
  wire sel_s;
  wire pdn_s;
  // Data and clock share one filter depth, so a bit is always settled before its edge is seen.
  eqsl_sync u_sck (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(shift_clock),
    .level_out(sck_s)
  );
  eqsl_sync u_sid (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(serial_in),
    .level_out(sid_s)
  );
  eqsl_sync u_load_latch_strobe (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(load_latch_strobe),
    .level_out(load_latch_strobe_s)
  );
  eqsl_sync u_readback_strobe (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(readback_strobe),
    .level_out(readback_strobe_s)
  );
  eqsl_sync u_sel (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(clock_rate_select),
    .level_out(sel_s)
  );
  eqsl_sync u_pdn (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(power_down_pin),
    .level_out(pdn_s)
  );

  reg sck_prev_q;
  wire sck_rise;
  wire sck_fall;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  // ==========================================================
  // Shift register and holding latch
  // ==========================================================
  // Neither store is reset, so a word survives a reset of the control logic.
  reg [`EQSL_WORD_W-1:0] shift_q;
  reg [`EQSL_WORD_W-1:0] latch_q;

  reg [`EQSL_WORD_W-1:0] shift_d;
  reg [`EQSL_WORD_W-1:0] latch_d;
  reg spill_q;
  reg spill_d;

  // Bit 0 enters first and ends at the low end after all fourteen shifts.
  // A readback wins over a shift edge, since the host must not clock during it.
  always @* begin
    shift_d = shift_q;
    spill_d = spill_q;
    if (readback_strobe_s) begin
      shift_d = latch_q;
    end else if (sck_rise) begin
      spill_d = shift_q[0];
      shift_d = {sid_s, shift_q[`EQSL_WORD_W-1:1]};
    end
  end

  // The bit that leaves on a rising edge waits for the falling edge to show it.
  // This puts bit 0 on serial_out at the first falling edge after a readback.
  always @(posedge sys_clk) begin
    shift_q <= shift_d;
    spill_q <= spill_d;
  end

  // The latch only moves on the load strobe, so shifting leaves it alone.
  always @* begin
    latch_d = latch_q;
    if (load_latch_strobe_s) begin
      latch_d = shift_q;
    end
  end

  // Both stores keep their value with no refresh, so any serial clock may stop.
  always @(posedge sys_clk) begin
    latch_q <= latch_d;
  end

  // ==========================================================
  // Field decoding
  // ==========================================================
  // One helper picks a four-bit code at a given low position of the latch.
  function [`EQSL_CODE_W-1:0] code_field;
    input [`EQSL_WORD_W-1:0] word;
    input integer lsb;
    begin
      code_field = word[lsb +: `EQSL_CODE_W];
    end
  endfunction

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
      slope_code <= 4'h0;
      height_code <= 4'h0;
      bandwidth_code <= 4'h0;
      slope_droop_select <= 1'b0;
      filter_bypass_n <= 1'b0;
      filter_path_en <= 1'b0;
      analog_power_en <= 1'b0;
      analog_output_oe <= 1'b0;
    end else begin
      if (sck_fall) begin
        serial_out <= spill_q;
      end
      slope_code <= code_field(latch_q, `EQSL_SLOPE_LSB);
      height_code <= code_field(latch_q, `EQSL_HEIGHT_LSB);
      bandwidth_code <= code_field(latch_q, `EQSL_BW_LSB);
      slope_droop_select <= latch_q[`EQSL_DROOP_BIT];
      filter_bypass_n <= latch_q[`EQSL_BYPASS_BIT];
      filter_path_en <= latch_q[`EQSL_BYPASS_BIT];
      analog_power_en <= ~pdn_s;
      analog_output_oe <= ~pdn_s;
    end
  end

  // ==========================================================
  // Filter clock swallower
  // ==========================================================
  // sys_clk stands in for the master clock; filter_clk_en marks kept cycles.
  // Powerdown freezes this counter and holds filter_clk_en low; the serial logic keeps running.
  reg [7:0] swallow_q;
  reg [7:0] swallow_d;
  reg clk_en_d;
  wire swallow_wrap;
  assign swallow_wrap = (swallow_q == `EQSL_SWALLOW_LAST);

  // The count wraps after its last position, so exactly one cycle per period is dropped.
  always @* begin
    swallow_d = swallow_q;
    clk_en_d = 1'b0;
    if (pdn_s) begin
      clk_en_d = 1'b0;
    end else if (sel_s) begin
      swallow_d = 8'h00;
      clk_en_d = 1'b1;
    end else begin
      if (swallow_wrap) begin
        swallow_d = 8'h00;
      end else begin
        swallow_d = swallow_q + 8'h01;
      end
      clk_en_d = ~swallow_wrap;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      swallow_q <= 8'h00;
      filter_clk_en <= 1'b0;
    end else begin
      swallow_q <= swallow_d;
      filter_clk_en <= clk_en_d;
    end
  end
endmodule

// >>> src/eqsl_consts.vh
`ifndef EQSL_CONSTS_VH
`define EQSL_CONSTS_VH
// Summary of operation
// - Capture serial_in on shift_clock rising edges.
// - Load strobe high copies shifter into latch.
// - Shifting never disturbs the held latch word.
// - Fourteen-bit latch drives filter controls directly.
// - Bit 0 shifts in first, ascending.
// - Readback strobe high copies latch into shifter.
// - serial_out advances on shift_clock falling edges.
// - Static storage; clocks may stop anytime.
// - Serial inputs are asynchronous to master clock.
// - Bypass bit zero routes around filters.
// - Select zero drops one cycle per 193.
// - Select one passes master clock unchanged.
// - Powerdown pin high removes analog power, floats output.
// - Powerdown keeps serial logic and word alive.
// - Master clock may stop during powerdown harmlessly.
// - Word holds four-bit slope code.
// - Word holds four-bit height code.
// - Word holds four-bit bandwidth code.
// - Word holds one slope droop bit.
`define EQSL_WORD_W 14
`define EQSL_SLOPE_LSB 0
`define EQSL_HEIGHT_LSB 4
`define EQSL_BW_LSB 8
`define EQSL_DROOP_BIT 12
`define EQSL_BYPASS_BIT 13
`define EQSL_CODE_W 4
`define EQSL_SWALLOW_PERIOD 8'd193
`define EQSL_SWALLOW_LAST 8'd192
`define EQSL_SYNC_W 3
`endif

// >>> src/eqsl_sync.v
`timescale 1ns/100ps
`include "eqsl_consts.vh"
// Three-stage input filter; the level changes only when stages two and three agree.
module eqsl_sync (
  sys_clk,
  sys_rst,
  pin_in,
  level_out
);
  input wire sys_clk;
  input wire sys_rst;
  input wire pin_in;
  output reg level_out;
  reg [`EQSL_SYNC_W-1:0] stage_q;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_q <= 3'h0;
      level_out <= 1'b0;
    end else begin
      stage_q <= {stage_q[1:0], pin_in};
      if (stage_q[1] == stage_q[2]) begin
        level_out <= stage_q[2];
      end
    end
  end
endmodule

// >>> bench/eqsl_props.sv
`timescale 1ns/100ps
// ====
// Field checks wait until a load has had eight cycles to settle, since the latch has no reset.
module eqsl_props (
  input wire sys_clk, sys_rst, shift_clock, load_latch_strobe, clock_rate_select, power_down_pin,
  input wire serial_out, filter_bypass_n, filter_path_en, filter_clk_en, analog_power_en, analog_output_oe
);
  reg [7:0] seen_q = 8'h00;
  always @(posedge sys_clk) begin
    seen_q <= {seen_q[6:0], seen_q[0] | load_latch_strobe};
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_path; seen_q[7] |-> filter_path_en == filter_bypass_n; endproperty
  a_path: assert property (p_path) else $error("path");
  property p_hold; (!load_latch_strobe && seen_q[7])[*8] |=> $stable(filter_bypass_n); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_sout; (shift_clock && seen_q[7])[*6] |=> $stable(serial_out); endproperty
  a_sout: assert property (p_sout) else $error("sout");
  property p_pdn; power_down_pin[*8] |-> !analog_power_en && !analog_output_oe; endproperty
  a_pdn: assert property (p_pdn) else $error("pdn");
  property p_run; (!power_down_pin)[*8] |-> analog_power_en && analog_output_oe; endproperty
  a_run: assert property (p_run) else $error("run");
  property p_pass; (clock_rate_select && !power_down_pin)[*8] |-> filter_clk_en; endproperty
  a_pass: assert property (p_pass) else $error("pass");
  property p_swal; (!power_down_pin)[*8] ##0 $fell(filter_clk_en) |=> filter_clk_en[*8]; endproperty
  a_swal: assert property (p_swal) else $error("swallow");
  property p_gate; power_down_pin[*8] |-> !filter_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("gate");
endmodule
bind eqsl_top eqsl_props u_props (.*);

// >>> bench/eqsl_host.sv
`timescale 1ns/100ps
// ====
// Shift clock idles low; the 3.3 ns offset keeps every edge clear of the system clock.
module eqsl_host (
  output reg shift_clock, serial_in, load_latch_strobe, readback_strobe,
  input wire serial_out
);
  initial {shift_clock, serial_in, load_latch_strobe, readback_strobe} = 4'h0;
  task xfer(input [13:0] w, output [13:0] r);
    integer i;
    begin
      #3.3;
      for (i = 0; i < 14; i = i + 1) begin
        if (i == 7) #1000;
        serial_in = w[i];
        #62.5 if (i > 0) r[i-1] = serial_out;
        shift_clock = 1'b1;
        #62.5 shift_clock = 1'b0;
      end
      #62.5 r[13] = serial_out;
      serial_in = ~w[13];
    end
  endtask
  task strobe(input rd);
    begin
      #65.8 load_latch_strobe = !rd;
      readback_strobe = rd;
      #62.5 {load_latch_strobe, readback_strobe} = 2'b00;
      #62.5;
    end
  endtask
endmodule

// >>> bench/eqsl_top_bench.sv
`timescale 1ns/100ps
// ====
// Each readback shifts the next word in, so the latch must hold meanwhile.
module eqsl_top_bench;
  reg sys_clk, sys_rst, clock_rate_select, power_down_pin;
  wire shift_clock, serial_in, load_latch_strobe, readback_strobe, serial_out, slope_droop_select;
  wire filter_bypass_n, filter_path_en, filter_clk_en, analog_power_en, analog_output_oe;
  wire [3:0] slope_code, height_code, bandwidth_code;
  wire [13:0] shown = {filter_bypass_n, slope_droop_select, bandwidth_code, height_code, slope_code};
  integer errors, checks, seed, n, k;
  reg [13:0] cur, nxt, got;
  eqsl_host host (.*);
  eqsl_top dut (.*);
  function [13:0] fields_of(input [13:0] w);
    fields_of = {w[13], w[12], w[11:8], w[7:4], w[3:0]};
  endfunction
  task cmp(input [63:0] nm, input [13:0] e, input [13:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("mismatch %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    errors = errors + 1;
    conclude;
  end
  initial begin
    {errors, checks, seed} = {32'h0, 32'h0, 32'h7F2D9385};
    {sys_rst, clock_rate_select, power_down_pin} = 3'b100;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cur = 14'h2AAA;
    host.xfer(cur, got);
    for (k = 0; k < 8; k = k + 1) begin
      host.strobe(1'b0);
      repeat (8) @(posedge sys_clk);
      cmp("fields", fields_of(cur), shown);
      power_down_pin <= k[0];
      n = $random(seed);
      nxt = k == 0 ? 14'h3FFF : k == 1 ? 14'h0000 : n[13:0];
      host.strobe(1'b1);
      host.xfer(nxt, got);
      cmp("readback", cur, got);
      cmp("held", fields_of(cur), shown);
      cur = nxt;
    end
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge sys_clk);
      power_down_pin <= 1'b0;
      clock_rate_select <= k[0];
      repeat (8) @(posedge sys_clk);
      n = 0;
      repeat (579) begin
        @(posedge sys_clk);
        #1 if (filter_clk_en === 1'b0) n = n + 1;
      end
      cmp("swallows", k[0] ? 14'h0000 : 14'h0003, n[13:0]);
    end
    conclude;
  end
endmodule
